/* hw/rate_conv_pkg.sv */
package rate_conv_pkg;

    // ****************************************
    // Register bus shape
    // ****************************************
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [15:0] CONV1_PATH_ADDR   = 16'h0ef2;
    localparam logic [15:0] CONV2_HIGH_ADDR   = 16'h0ef3;
    localparam logic [15:0] CONV2_LOW_ADDR    = 16'h0ef4;
    localparam logic [15:0] CONV2_PATH_ADDR   = 16'h0ef5;
    localparam logic [15:0] CONV1_ACTIVE_ADDR = 16'h0f00;
    localparam logic [15:0] CONV2_ACTIVE_ADDR = 16'h0f01;

    // ****************************************
    // Field layout and reset values
    // ****************************************
    localparam int RATE_MSB  = 14;
    localparam int RATE_LSB  = 11;
    localparam int UP_MSB    = 15;
    localparam int UP_LSB    = 12;
    localparam int DOWN_MSB  = 9;
    localparam int DOWN_LSB  = 6;
    localparam int NOTCH_BIT = 0;
    localparam int FAULT_BIT = 1;
    localparam logic [3:0]  RATE_RESET = 4'h0;
    localparam logic [15:0] REG_RESET  = 16'h0000;
    localparam logic [15:0] PATH_MASK  = 16'hf3c1;

    // ****************************************
    // Rate codes
    // ****************************************
    localparam logic [3:0] RATE_SYNC1  = 4'h0;
    localparam logic [3:0] RATE_SYNC2  = 4'h1;
    localparam logic [3:0] RATE_SYNC3  = 4'h2;
    localparam logic [3:0] RATE_ASYNC1 = 4'h8;
    localparam logic [3:0] RATE_ASYNC2 = 4'h9;
    localparam logic [2:0] IDX_BAD     = 3'h7;
    localparam int         DOMAIN_BIT  = 3;

    // Coefficient index per rate code; reserved codes map to IDX_BAD
    function automatic logic [2:0] rate_idx(input logic [3:0] code);
        if (code == RATE_SYNC1) rate_idx = 3'h0;
        else if (code == RATE_SYNC2) rate_idx = 3'h1;
        else if (code == RATE_SYNC3) rate_idx = 3'h2;
        else if (code == RATE_ASYNC1) rate_idx = 3'h3;
        else if (code == RATE_ASYNC2) rate_idx = 3'h4;
        else rate_idx = IDX_BAD;
    endfunction

    // Eight path bits of a control word: {up[3:0], down[3:0]}
    function automatic logic [7:0] path_bits(input logic [15:0] w);
        path_bits = {w[UP_MSB:UP_LSB], w[DOWN_MSB:DOWN_LSB]};
    endfunction

    // Inverse of path_bits, placing bits at their register positions
    function automatic logic [15:0] path_word(input logic [7:0] p);
        path_word = REG_RESET;
        path_word[UP_MSB:UP_LSB] = p[7:4];
        path_word[DOWN_MSB:DOWN_LSB] = p[3:0];
    endfunction

endpackage

/* hw/path_admit_if.sv */
`timescale 1ns/1ps
interface path_admit_if #(
    parameter int PATHS = 16,
    parameter int CNT_W = 5
);
    logic [PATHS-1:0] requested;
    logic [PATHS-1:0] active;
    logic [PATHS-1:0] next_active;
    logic [CNT_W-1:0] budget;

    modport admit (input requested, input active, input budget, output next_active);
    modport ctrl (output requested, output active, output budget, input next_active);
endinterface

/* hw/path_admit.sv */
`timescale 1ns/1ps
module path_admit #(
    parameter int PATHS = 16,
    parameter int CNT_W = 5
) (
    // Request, current state and clock budget
    path_admit_if.admit bus
);

    function automatic logic [CNT_W-1:0] count_ones(input logic [PATHS-1:0] v);
        count_ones = '0;
        for (int i = 0; i < PATHS; i++) begin
            count_ones = CNT_W'(count_ones + CNT_W'(v[i]));
        end
    endfunction

    logic [PATHS-1:0] kept;
    logic [PATHS-1:0] fresh;

    assign kept  = bus.active & bus.requested;
    assign fresh = bus.requested & ~bus.active;

    // Running paths are counted first, so a lowered budget never drops them; new
    // paths are granted lowest bit first while cycles remain (see [RULE16])
    always_comb begin
        logic [CNT_W-1:0] used;
        used = count_ones(kept);
        bus.next_active = kept;
        for (int i = 0; i < PATHS; i++) begin
            if (fresh[i] && (used < bus.budget)) begin
                bus.next_active[i] = 1'b1;
                used = CNT_W'(used + CNT_W'(1));
            end
        end
    end

endmodule

/* hw/rate_converter_path_control.sv */
`timescale 1ns/1ps
// Behaviour
// [RULE1] Converter 2 high-rate code in bits 14:11
// [RULE2] Converter 2 low-rate code, two async codes
// [RULE3] Software writes only the five defined codes
// [RULE4] Software keeps rates within 8 to 192 kHz
// [RULE5] Both rate fields share one clock domain
// [RULE6] Clear downsample inputs before changing high rate
// [RULE7] Clear upsample inputs before changing low rate
// [RULE8] Converter 2 bits 15:12 enable upsample channels
// [RULE9] Converter 2 bits 9:6 enable downsample channels
// [RULE10] Converter 2 bit 0 enables notch filter
// [RULE11] Software should normally enable the notch
// [RULE12] Converter 1 bits 8:6 enable downsample 2-4
// [RULE13] Converter 1 bit 0 enables notch filter
// [RULE14] Reset clears rates and every enable
// [RULE15] Notch coefficients follow the rates automatically
// [RULE16] Unaffordable new paths refused, running paths kept
module rate_converter_path_control #(
    parameter int PATHS = 16,
    parameter int CNT_W = 5
) (
    // Clock and reset
    input  wire logic                                clk,
    input  wire logic                                sys_rst,
    // Register port
    input  wire logic [rate_conv_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [rate_conv_pkg::DATA_W-1:0]    reg_wr_data,
    input  wire logic                                reg_wr,
    input  wire logic                                reg_rd,
    output logic      [rate_conv_pkg::DATA_W-1:0]    reg_rd_data,
    // Paths the system clock can carry
    input  wire logic [CNT_W-1:0]                    path_budget,
    // Converter 1 path controls
    output logic      [3:0]                          conv1_upsample_en,
    output logic      [3:0]                          conv1_downsample_en,
    output logic                                     conv1_notch_en,
    // Converter 2 path controls
    output logic      [3:0]                          conv2_upsample_en,
    output logic      [3:0]                          conv2_downsample_en,
    output logic                                     conv2_notch_en,
    output logic      [5:0]                          conv2_notch_coef_sel,
    output logic                                     conv2_rate_fault
);

    // ****************************************
    // Stored configuration
    // ****************************************
    logic [3:0]       conv2_high_rate_sel;
    logic [3:0]       conv2_low_rate_sel;
    logic [15:0]      conv1_path_enable_ctrl;
    logic [15:0]      conv2_path_enable_ctrl;
    logic [PATHS-1:0] active;

    // ****************************************
    // Address decode
    // ****************************************
    wire hit_c1_path = (reg_addr == rate_conv_pkg::CONV1_PATH_ADDR);
    wire hit_high    = (reg_addr == rate_conv_pkg::CONV2_HIGH_ADDR);
    wire hit_low     = (reg_addr == rate_conv_pkg::CONV2_LOW_ADDR);
    wire hit_c2_path = (reg_addr == rate_conv_pkg::CONV2_PATH_ADDR);
    wire hit_c1_act  = (reg_addr == rate_conv_pkg::CONV1_ACTIVE_ADDR);
    wire hit_c2_act  = (reg_addr == rate_conv_pkg::CONV2_ACTIVE_ADDR);

    wire [3:0]  wr_rate  = reg_wr_data[rate_conv_pkg::RATE_MSB:rate_conv_pkg::RATE_LSB];
    wire [15:0] wr_paths = reg_wr_data & rate_conv_pkg::PATH_MASK;

    // ****************************************
    // Rate checks and notch coefficients
    // ****************************************
    wire [2:0] high_idx = rate_conv_pkg::rate_idx(conv2_high_rate_sel);
    wire [2:0] low_idx  = rate_conv_pkg::rate_idx(conv2_low_rate_sel);
    // Reserved codes and mixed domains are software faults; flagged, not blocked
    wire next_fault = (high_idx == rate_conv_pkg::IDX_BAD)
                    || (low_idx == rate_conv_pkg::IDX_BAD)
                    || (conv2_high_rate_sel[rate_conv_pkg::DOMAIN_BIT]
                        != conv2_low_rate_sel[rate_conv_pkg::DOMAIN_BIT]);

    // ****************************************
    // Path admission
    // ****************************************
    path_admit_if #(.PATHS(PATHS), .CNT_W(CNT_W)) adm ();

    assign adm.requested = {rate_conv_pkg::path_bits(conv2_path_enable_ctrl),
                            rate_conv_pkg::path_bits(conv1_path_enable_ctrl)};
    assign adm.active    = active;
    assign adm.budget    = path_budget;

    path_admit #(.PATHS(PATHS), .CNT_W(CNT_W)) u_admit (
        .bus (adm)
    );

    // ****************************************
    // Read data selection
    // ****************************************
    wire [15:0] c1_status = rate_conv_pkg::path_word(active[7:0]);
    wire [15:0] c2_status = rate_conv_pkg::path_word(active[15:8])
                          | (16'(conv2_rate_fault) << rate_conv_pkg::FAULT_BIT);
    wire [15:0] high_word = 16'(conv2_high_rate_sel) << rate_conv_pkg::RATE_LSB;
    wire [15:0] low_word  = 16'(conv2_low_rate_sel) << rate_conv_pkg::RATE_LSB;

    // Unmapped addresses read zero
    wire [15:0] next_rd_data = hit_c1_path ? conv1_path_enable_ctrl
                             : hit_high    ? high_word
                             : hit_low     ? low_word
                             : hit_c2_path ? conv2_path_enable_ctrl
                             : hit_c1_act  ? c1_status
                             : hit_c2_act  ? c2_status
                             : rate_conv_pkg::REG_RESET;

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            conv2_high_rate_sel <= rate_conv_pkg::RATE_RESET; // see [RULE14]
            conv2_low_rate_sel  <= rate_conv_pkg::RATE_RESET; // see [RULE14]
        end else if (reg_wr && hit_high) begin
            conv2_high_rate_sel <= wr_rate; // see [RULE1]
        end else if (reg_wr && hit_low) begin
            conv2_low_rate_sel <= wr_rate; // see [RULE2]
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            conv1_path_enable_ctrl <= rate_conv_pkg::REG_RESET; // see [RULE14]
            conv2_path_enable_ctrl <= rate_conv_pkg::REG_RESET; // see [RULE14]
        end else if (reg_wr && hit_c1_path) begin
            conv1_path_enable_ctrl <= wr_paths; // see [RULE12] see [RULE13]
        end else if (reg_wr && hit_c2_path) begin
            conv2_path_enable_ctrl <= wr_paths; // see [RULE8] see [RULE9] see [RULE10]
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            active               <= '0; // see [RULE14]
            conv2_notch_coef_sel <= '0;
            conv2_rate_fault     <= 1'b0;
            reg_rd_data          <= rate_conv_pkg::REG_RESET;
        end else begin
            active               <= adm.next_active; // see [RULE16]
            conv2_notch_coef_sel <= {high_idx, low_idx}; // see [RULE15]
            conv2_rate_fault     <= next_fault;
            reg_rd_data          <= reg_rd ? next_rd_data : rate_conv_pkg::REG_RESET;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign conv1_upsample_en   = active[7:4];
    assign conv1_downsample_en = active[3:0]; // see [RULE12]
    assign conv2_upsample_en   = active[15:12]; // see [RULE8]
    assign conv2_downsample_en = active[11:8]; // see [RULE9]
    assign conv1_notch_en = conv1_path_enable_ctrl[rate_conv_pkg::NOTCH_BIT]; // see [RULE13]
    assign conv2_notch_en = conv2_path_enable_ctrl[rate_conv_pkg::NOTCH_BIT]; // see [RULE10]

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    high_rate_a: assert property ( // see [RULE1]
        reg_wr && hit_high |=> conv2_high_rate_sel == $past(wr_rate) ##1
            conv2_notch_coef_sel[5:3] == rate_conv_pkg::rate_idx($past(conv2_high_rate_sel)))
        else $error("high rate field not stored or coded");

    low_rate_a: assert property ( // see [RULE2]
        reg_wr && hit_low |=> conv2_low_rate_sel == $past(wr_rate))
        else $error("low rate field not stored");

    up_enable_a: assert property ( // see [RULE8]
        reg_wr && hit_c2_path ##1 path_budget >= CNT_W'(PATHS)
        |=> conv2_upsample_en == $past(reg_wr_data[15:12], 2))
        else $error("upsample enables do not follow write");

    down_enable_a: assert property ( // see [RULE9]
        reg_wr && hit_c2_path ##1 path_budget >= CNT_W'(PATHS)
        |=> conv2_downsample_en == $past(reg_wr_data[9:6], 2))
        else $error("downsample enables do not follow write");

    notch2_a: assert property ( // see [RULE10]
        reg_wr && hit_c2_path |=> conv2_notch_en == $past(reg_wr_data[0]))
        else $error("converter 2 notch enable wrong");

    conv1_down_a: assert property ( // see [RULE12]
        reg_wr && hit_c1_path ##1 path_budget >= CNT_W'(PATHS)
        |=> conv1_downsample_en[2:0] == $past(reg_wr_data[8:6], 2))
        else $error("converter 1 downsample enables wrong");

    notch1_a: assert property ( // see [RULE13]
        reg_wr && hit_c1_path |=> conv1_notch_en == $past(reg_wr_data[0]))
        else $error("converter 1 notch enable wrong");

    reset_clear_a: assert property ( // see [RULE14]
        $past(sys_rst) |-> active == '0 && conv2_high_rate_sel == 4'h0
            && conv2_low_rate_sel == 4'h0 && !conv1_notch_en && !conv2_notch_en)
        else $error("state not cleared by reset");

    coef_track_a: assert property ( // see [RULE15]
        $stable(conv2_high_rate_sel) && $stable(conv2_low_rate_sel)
        |-> conv2_notch_coef_sel == {high_idx, low_idx})
        else $error("notch coefficients do not match rates");

    keep_active_a: assert property ( // see [RULE16]
        1'b1 |=> ($past(active & adm.requested) & ~active) == '0)
        else $error("running path dropped");

    refuse_new_a: assert property ( // see [RULE16]
        path_budget == '0 |=> (active & ~$past(active)) == '0)
        else $error("path granted without clock budget");

    drop_unrequested_a: assert property ( // see [RULE16]
        1'b1 |=> (active & ~$past(adm.requested)) == '0)
        else $error("path active without a request");

    grant_limit_a: assert property ( // see [RULE16]
        1'b1 |=> (active & ~$past(active)) == '0 || $countones(active) <= $past(path_budget))
        else $error("new path granted beyond the clock budget");

    // ****************************************
    // Readback, hold and fault checks
    // ****************************************
    // Read data falls back to zero so a stale word is never taken twice
    rd_idle_a: assert property (
        !reg_rd |=> reg_rd_data == rate_conv_pkg::REG_RESET)
        else $error("read data not zero outside a read");

    rd_high_a: assert property ( // see [RULE1]
        reg_rd && hit_high |=> reg_rd_data[rate_conv_pkg::RATE_MSB:rate_conv_pkg::RATE_LSB]
            == $past(conv2_high_rate_sel))
        else $error("high rate field reads back wrong");

    rd_low_a: assert property ( // see [RULE2]
        reg_rd && hit_low |=> reg_rd_data[rate_conv_pkg::RATE_MSB:rate_conv_pkg::RATE_LSB]
            == $past(conv2_low_rate_sel))
        else $error("low rate field reads back wrong");

    // Only the rate field exists in a rate register; the rest must read zero
    rd_rate_mask_a: assert property ( // see [RULE1]
        reg_rd && (hit_high || hit_low)
        |=> reg_rd_data[15] == 1'b0 && reg_rd_data[10:0] == 11'h000)
        else $error("unused rate register bits read nonzero");

    rd_c2_mask_a: assert property ( // see [RULE9]
        reg_rd && hit_c2_path |=> (reg_rd_data & ~rate_conv_pkg::PATH_MASK) == 16'h0000)
        else $error("converter 2 path register holds unused bits");

    rd_c1_mask_a: assert property ( // see [RULE12]
        reg_rd && hit_c1_path |=> (reg_rd_data & ~rate_conv_pkg::PATH_MASK) == 16'h0000)
        else $error("converter 1 path register holds unused bits");

    rd_status_a: assert property ( // see [RULE16]
        reg_rd && hit_c2_act
        |=> reg_rd_data[rate_conv_pkg::UP_MSB:rate_conv_pkg::UP_LSB] == $past(conv2_upsample_en)
            && reg_rd_data[rate_conv_pkg::FAULT_BIT] == $past(conv2_rate_fault))
        else $error("converter 2 status reads back wrong");

    rd_c1_status_a: assert property ( // see [RULE12]
        reg_rd && hit_c1_act |=> reg_rd_data[rate_conv_pkg::DOWN_MSB:rate_conv_pkg::DOWN_LSB]
            == $past(conv1_downsample_en))
        else $error("converter 1 status reads back wrong");

    rd_unmapped_a: assert property (
        reg_rd && !(hit_c1_path || hit_high || hit_low || hit_c2_path
                    || hit_c1_act || hit_c2_act)
        |=> reg_rd_data == rate_conv_pkg::REG_RESET)
        else $error("unmapped address reads nonzero");

    // Rate fields move only on their own write, so coefficients never switch unasked
    high_hold_a: assert property ( // see [RULE1]
        !(reg_wr && hit_high) |=> $stable(conv2_high_rate_sel))
        else $error("high rate field changed without a write");

    low_hold_a: assert property ( // see [RULE2]
        !(reg_wr && hit_low) |=> $stable(conv2_low_rate_sel))
        else $error("low rate field changed without a write");

    notch_hold_a: assert property ( // see [RULE10]
        !(reg_wr && (hit_c1_path || hit_c2_path))
        |=> $stable(conv1_notch_en) && $stable(conv2_notch_en))
        else $error("notch enable changed without a write");

    fault_code_a: assert property ( // see [RULE1]
        high_idx == rate_conv_pkg::IDX_BAD || low_idx == rate_conv_pkg::IDX_BAD
        |=> conv2_rate_fault)
        else $error("reserved rate code not flagged");

    fault_domain_a: assert property ( // see [RULE2]
        conv2_high_rate_sel[rate_conv_pkg::DOMAIN_BIT]
            != conv2_low_rate_sel[rate_conv_pkg::DOMAIN_BIT] |=> conv2_rate_fault)
        else $error("mixed clock domains not flagged");

    fault_clear_a: assert property ( // see [RULE2]
        high_idx != rate_conv_pkg::IDX_BAD && low_idx != rate_conv_pkg::IDX_BAD
        && conv2_high_rate_sel[rate_conv_pkg::DOMAIN_BIT]
            == conv2_low_rate_sel[rate_conv_pkg::DOMAIN_BIT] |=> !conv2_rate_fault)
        else $error("rate fault raised for a legal setting");

    cover_c2_path_c: cover property (reg_wr && hit_c2_path ##2 conv2_upsample_en != 4'h0);
    cover_budget_c:  cover property (path_budget == '0 && active != '0);
    cover_refused_c: cover property (adm.requested != active ##1 adm.requested != active);
    cover_fault_c:   cover property (conv2_rate_fault);
    cover_read_c:    cover property (reg_rd && hit_c2_act ##1 reg_rd_data != 16'h0000);

endmodule

/* tb/mix_core_model.sv */
`timescale 1ns/1ps
// ****************************************
// Mixing core clock budget
// ****************************************
module mix_core_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Budget asked for by the bench
    input  wire logic [4:0] target,
    input  wire logic       slow,
    // Paths the system clock can carry
    output logic      [4:0] path_budget
);
    // Slow mode walks one path per cycle, like a clock ramping up or down
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            path_budget <= 5'h10;
        end else if (!slow || path_budget == target) begin
            path_budget <= target;
        end else if (path_budget < target) begin
            path_budget <= path_budget + 5'h1;
        end else begin
            path_budget <= path_budget - 5'h1;
        end
    end
endmodule

/* tb/rate_converter_path_control_tb.sv */
`timescale 1ns/1ps
module rate_converter_path_control_tb;
    logic        clk, sys_rst, reg_wr, reg_rd, slow;
    logic [15:0] reg_addr, reg_wr_data, reg_rd_data;
    logic [4:0]  path_budget, target;
    logic [3:0]  c1_up, c1_dn, c2_up, c2_dn;
    logic        c1_notch, c2_notch, c2_fault;
    logic [5:0]  c2_coef;
    int          miscompares = 0;
    int          n_compared = 0;
    logic [15:0] m_c1, m_c2, m_hi, m_lo, m_act, m_rd;
    logic [5:0]  m_coef;
    logic        m_flt;
    logic [15:0] addrs [7] = '{16'h0ef2, 16'h0ef3, 16'h0ef4, 16'h0ef5,
                               16'h0f00, 16'h0f01, 16'h0ef6};
    logic [15:0] r_addr, r_data;
    logic [3:0]  codes [6] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'h5};

    rate_converter_path_control i_dut (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .path_budget(path_budget),
        .conv1_upsample_en(c1_up), .conv1_downsample_en(c1_dn), .conv1_notch_en(c1_notch),
        .conv2_upsample_en(c2_up), .conv2_downsample_en(c2_dn), .conv2_notch_en(c2_notch),
        .conv2_notch_coef_sel(c2_coef), .conv2_rate_fault(c2_fault));
    mix_core_model i_budget (.clk(clk), .sys_rst(sys_rst), .target(target), .slow(slow),
        .path_budget(path_budget));

    // ****************************************
    // Reference model
    // ****************************************
    function automatic logic [2:0] ix(input logic [3:0] c);
        case (c)
            4'h0, 4'h1, 4'h2: return c[2:0];
            4'h8, 4'h9: return c[2:0] + 3'h3;
            default: return 3'h7;
        endcase
    endfunction
    function automatic logic [7:0] pb(input logic [15:0] w);
        return {w[15:12], w[9:6]};
    endfunction
    // Running paths stay; new ones granted lowest index first while budget lasts
    function automatic logic [15:0] admit(input logic [15:0] req, act, input int bud);
        logic [15:0] n;
        int cnt;
        n = req & act;
        cnt = $countones(n);
        for (int i = 0; i < 16; i++) begin
            if (req[i] && !n[i] && cnt < bud) begin
                n[i] = 1'b1;
                cnt++;
            end
        end
        return n;
    endfunction
    function logic [15:0] rdv(input logic [15:0] a);
        case (a)
            16'h0ef2: return m_c1;
            16'h0ef3: return m_hi;
            16'h0ef4: return m_lo;
            16'h0ef5: return m_c2;
            16'h0f00: return {m_act[7:4], 2'h0, m_act[3:0], 6'h00};
            16'h0f01: return {m_act[15:12], 2'h0, m_act[11:8], 4'h0, m_flt, 1'b0};
            default: return 16'h0000;
        endcase
    endfunction
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {m_c1, m_c2, m_hi, m_lo, m_act, m_rd} <= '0;
            m_coef <= 6'h00;
            m_flt <= 1'b0;
        end else begin
            m_act <= admit({pb(m_c2), pb(m_c1)}, m_act, int'(path_budget));
            m_coef <= {ix(m_hi[14:11]), ix(m_lo[14:11])};
            m_flt <= ix(m_hi[14:11]) == 3'h7 || ix(m_lo[14:11]) == 3'h7 || m_hi[14] != m_lo[14];
            m_rd <= reg_rd ? rdv(reg_addr) : 16'h0000;
            if (reg_wr) begin
                case (reg_addr)
                    16'h0ef2: m_c1 <= reg_wr_data & 16'hf3c1;
                    16'h0ef3: m_hi <= reg_wr_data & 16'h7800;
                    16'h0ef4: m_lo <= reg_wr_data & 16'h7800;
                    16'h0ef5: m_c2 <= reg_wr_data & 16'hf3c1;
                    default: ;
                endcase
            end
        end
    end

    // ****************************************
    // Comparison and verdict
    // ****************************************
    task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t read data got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_ctl(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t control got %h exp %h", $time, got, exp);
        end
    endtask
    always @(negedge clk) begin
        chk_rd(reg_rd_data, m_rd);
        chk_ctl({c2_up, c2_dn, c1_up, c1_dn}, m_act);
        chk_ctl({14'h0000, c2_notch, c1_notch}, {14'h0000, m_c2[0], m_c1[0]});
        chk_ctl({9'h000, c2_fault, c2_coef}, {9'h000, m_flt, m_coef});
    end
    task automatic wrap_up;
        if (miscompares == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ****************************************
    // Stimulus
    // ****************************************
    // Strobes stay up between calls, so back-to-back transfers need no gap
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wr_data <= d;
    endtask
    task automatic idle(input int n);
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    function automatic logic [15:0] rw(input logic [3:0] c);
        return {1'($urandom), c, 11'($urandom)};
    endfunction
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
    initial begin
        {sys_rst, reg_wr, reg_rd, slow} = 4'h8;
        {reg_addr, reg_wr_data} = '0;
        target = 5'h10;
        void'($urandom(32'h57bf_ab37));
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (addrs[i]) xfer(1'b0, addrs[i], 16'h0000);
        // Deliberate misuse, a reserved code and mixed domains, to exercise the fault flag.
        // Source selects sit outside this block and stay at zero across rate changes.
        foreach (codes[h]) begin
            foreach (codes[l]) begin
                xfer(1'b1, 16'h0ef3, rw(codes[h]));
                xfer(1'b1, 16'h0ef4, rw(codes[l]));
                xfer(1'b0, 16'h0ef3, 16'h0000);
                xfer(1'b0, 16'h0f01, 16'h0000);
                idle(1);
            end
        end
        xfer(1'b1, 16'h0ef3, rw(codes[0]));
        xfer(1'b1, 16'h0ef4, rw(codes[0]));
        repeat (40) begin
            xfer(1'b1, $urandom_range(1) ? 16'h0ef5 : 16'h0ef2, 16'($urandom));
            xfer(1'b0, addrs[$urandom_range(6)], 16'h0000);
        end
        // Too few clock cycles: budget drops to three, running paths stay and new ones wait
        target <= 5'h03;
        xfer(1'b1, 16'h0ef2, 16'hffff);
        xfer(1'b1, 16'h0ef5, 16'hffff);
        idle(3);
        xfer(1'b0, 16'h0f00, 16'h0000);
        xfer(1'b0, 16'h0f01, 16'h0000);
        slow <= 1'b1;
        target <= 5'h00;
        idle(20);
        xfer(1'b1, 16'h0ef2, 16'h0000);
        idle(3);
        target <= 5'h10;
        idle(25);
        repeat (300) begin
            if ($urandom_range(9) == 0) begin
                target <= 5'($urandom_range(16));
                slow <= 1'($urandom);
            end
            r_addr = addrs[$urandom_range(6)];
            // Rate writes keep to defined system-clock codes, so both fields share a domain
            r_data = (r_addr == 16'h0ef3 || r_addr == 16'h0ef4) ? rw(codes[$urandom_range(2)])
                                                                 : 16'($urandom);
            xfer(1'($urandom), r_addr, r_data);
        end
        idle(1);
        sys_rst <= 1'b1;
        idle(2);
        sys_rst <= 1'b0;
        foreach (addrs[i]) xfer(1'b0, addrs[i], 16'h0000);
        idle(4);
        wrap_up();
    end
endmodule
